// >>> scg_checker.sv
// Concurrent checks on the ports of the clock generation block
`timescale 1ns/10ps
module scg_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Straps and register port
  input wire logic HOST_MODE_STRAP,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Clock outputs
  input wire logic SYNC_CLK_OUT,
  input wire logic [2:0] BUS_CLOCK_OUTPUTS,
  input wire logic [3:0] CSB_SYNC_RATIO,
  input wire logic [3:0] CORE_RATIO_HALVES,
  input wire logic CORE_PLL_ON,
  input wire logic CSB_CLK_EN,
  input wire logic MEM_BUS_CLK_P,
  input wire logic MEM_BUS_CLK_N,
  input wire logic [1:0] LOCAL_BUS_CLOCK_OUT,
  input wire logic ETH1_CLK_EN,
  input wire logic PCI_DMA_CLK_EN,
  // Status
  input wire logic CFG_VALID,
  input wire logic CFG_ERROR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // --------------------
  // Tick cadence
  // --------------------
  // A bus tick is followed by exactly one idle cycle
  sequence csb_gap;
    !CSB_CLK_EN ##1 CSB_CLK_EN;
  endsequence
  chk_csb_tick_cadence: assert property (CSB_CLK_EN |=> csb_gap)
    else $error("bus tick cadence broken");
  chk_pci_on_tick: assert property (PCI_DMA_CLK_EN |-> CSB_CLK_EN)
    else $error("pci pulse off the bus tick");
  // A unit can never pulse faster than the bus tick, even while switching
  chk_unit_no_glitch: assert property (ETH1_CLK_EN |=> !ETH1_CLK_EN)
    else $error("unit pulses back to back");
  // --------------------
  // Output pairs and bus clock outputs
  // --------------------
  chk_mem_pair_inverse: assert property (MEM_BUS_CLK_N == !MEM_BUS_CLK_P)
    else $error("memory clock pair not inverse");
  chk_local_bus_clock_out_pair_equal: assert property (LOCAL_BUS_CLOCK_OUT[0] == LOCAL_BUS_CLOCK_OUT[1])
    else $error("local bus clock pair differs");
  chk_bus_out_follows: assert property (|BUS_CLOCK_OUTPUTS |->
    (SYNC_CLK_OUT || $past(SYNC_CLK_OUT) || $past(SYNC_CLK_OUT, 2)))
    else $error("bus clock high without sync clock");
  chk_agent_quiet: assert property ($past(CFG_VALID, 3) && !HOST_MODE_STRAP |->
    !SYNC_CLK_OUT && BUS_CLOCK_OUTPUTS == 3'h0)
    else $error("sync driven in agent mode");
  // --------------------
  // Ratios, valid one cycle after the status; read data idle
  // --------------------
  chk_bypass_ratio: assert property ($past(CFG_VALID, 2) && !CFG_ERROR && !CORE_PLL_ON |->
    CORE_RATIO_HALVES == 4'h2)
    else $error("bypass ratio not one");
  chk_core_ratio_range: assert property ($past(CFG_VALID, 2) && !CFG_ERROR |->
    CORE_RATIO_HALVES inside {[4'h2:4'h6]})
    else $error("core ratio out of range");
  chk_csb_ratio_range: assert property ($past(CFG_VALID, 2) && !CFG_ERROR |->
    CSB_SYNC_RATIO inside {[4'h2:4'hC]})
    else $error("bus ratio out of range");
  chk_read_data_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its cycle");
endmodule : scg_checker

bind scg_clock_gen scg_checker u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .HOST_MODE_STRAP(HOST_MODE_STRAP),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SYNC_CLK_OUT(SYNC_CLK_OUT), .BUS_CLOCK_OUTPUTS(BUS_CLOCK_OUTPUTS),
  .CSB_SYNC_RATIO(CSB_SYNC_RATIO), .CORE_RATIO_HALVES(CORE_RATIO_HALVES), .CORE_PLL_ON(CORE_PLL_ON),
  .CSB_CLK_EN(CSB_CLK_EN), .MEM_BUS_CLK_P(MEM_BUS_CLK_P), .MEM_BUS_CLK_N(MEM_BUS_CLK_N),
  .LOCAL_BUS_CLOCK_OUT(LOCAL_BUS_CLOCK_OUT), .ETH1_CLK_EN(ETH1_CLK_EN), .PCI_DMA_CLK_EN(PCI_DMA_CLK_EN),
  .CFG_VALID(CFG_VALID), .CFG_ERROR(CFG_ERROR));

// >>> scg_clock_gen.sv
// System clock generation: reference select, dividers, unit rates, registers
`timescale 1ns/10ps
module scg_clock_gen (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Reference clock pins, sampled as levels
  input wire logic SYS_REF_CLK_IN,
  input wire logic BUS_CLK_IN,
  // Configuration straps
  input wire logic HOST_MODE_STRAP,
  input wire logic INPUT_DIVIDER_STRAP,
  input wire logic RCW_HARD_SEL,
  input wire logic [15:0] RCW_EXT_LOW,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Reference and bus clock outputs
  output logic PRIMARY_REF_CLK,
  output logic SYNC_CLK_OUT,
  output logic [2:0] BUS_CLOCK_OUTPUTS,
  // Derived ratios
  output logic [3:0] CSB_SYNC_RATIO,
  output logic [3:0] CORE_RATIO_HALVES,
  output logic CORE_PLL_ON,
  // Memory and local bus clocks
  output logic CSB_CLK_EN,
  output logic MEM_DATA_EN,
  output logic MEM_BUS_CLK_P,
  output logic MEM_BUS_CLK_N,
  output logic LBC_CLK_EN,
  output logic [1:0] LOCAL_BUS_CLOCK_OUT,
  // Unit clock enables
  output logic ETH1_CLK_EN,
  output logic ETH2_CLK_EN,
  output logic SEC_CLK_EN,
  output logic USB_CLK_EN,
  output logic PCI_DMA_CLK_EN,
  // Configuration status
  output logic CFG_VALID,
  output logic CFG_ERROR
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [1:0] sys_ref_sync_reg;
  logic [1:0] bus_ref_sync_reg;
  logic [1:0] host_sync_reg;
  logic [1:0] div_sync_reg;
  logic [1:0] hard_sync_reg;
  logic [15:0] rcw_sync1_reg;
  logic [15:0] rcw_sync2_reg;
  scg_pkg::scg_state_t state_reg;
  logic [1:0] wait_cnt_reg;
  logic [15:0] rcw_reg;
  logic host_reg;
  logic div_reg;
  logic sys_prev_reg;
  logic half_reg;
  logic sync_reg;
  logic sync_prev_reg;
  logic [2:0] outen_reg;
  logic [2:0] gate_reg;
  logic [2:0] bus_out_reg;
  logic [1:0] lbdiv_reg;
  logic [8:0] units_reg;
  logic prim_reg;
  logic [3:0] csb_ratio_reg;
  logic [3:0] core_half_reg;
  logic core_on_reg;
  logic err_reg;
  logic phase_reg;
  logic csb_tick;
  logic ddr_tick;
  logic lbc_tick;
  logic csb_en_reg;
  logic ddr_en_reg;
  logic lbc_en_reg;
  logic memclk_reg;
  logic memclk_n_reg;
  logic [1:0] ldiv_act_reg;
  logic [1:0] lcnt_reg;
  logic lbclk_reg;
  logic [31:0] rdata_reg;
  logic [3:0] sys_mul;
  logic [6:0] core_fld;
  logic pci_en_reg;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Ticks of the local-bus internal clock per output half period, less one
  function automatic logic [1:0] lbc_half(input logic [1:0] code);
    unique case (code)
      scg_pkg::LDIV_2: lbc_half = 2'h0;
      scg_pkg::LDIV_4: lbc_half = 2'h1;
      default: lbc_half = 2'h3;
    endcase
  endfunction : lbc_half

  // Core multiplier in halves; bypass reads as 1:1
  function automatic logic [3:0] core_halves(input logic [6:0] fld);
    logic [3:0] m;
    m = fld[4:1];
    if (m == 4'h0) begin
      core_halves = 4'h2;
    end else begin
      core_halves = 4'((m << 1) + {3'h0, fld[0]});
    end
  endfunction : core_halves

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Two stages before any logic looks at a pin
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sys_ref_sync_reg <= 2'h0;
      bus_ref_sync_reg <= 2'h0;
      host_sync_reg <= 2'h0;
      div_sync_reg <= 2'h0;
      hard_sync_reg <= 2'h0;
      rcw_sync1_reg <= 16'h0000;
      rcw_sync2_reg <= 16'h0000;
    end else begin
      sys_ref_sync_reg <= {sys_ref_sync_reg[0], SYS_REF_CLK_IN};
      bus_ref_sync_reg <= {bus_ref_sync_reg[0], BUS_CLK_IN};
      host_sync_reg <= {host_sync_reg[0], HOST_MODE_STRAP};
      div_sync_reg <= {div_sync_reg[0], INPUT_DIVIDER_STRAP};
      hard_sync_reg <= {hard_sync_reg[0], RCW_HARD_SEL};
      rcw_sync1_reg <= RCW_EXT_LOW;
      rcw_sync2_reg <= rcw_sync1_reg;
    end
  end

  // ------------------------------------------------------------
  // Reset configuration capture
  // ------------------------------------------------------------
  // Straps are caught once, after the synchronisers have filled
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= scg_pkg::ST_WAIT;
      wait_cnt_reg <= 2'h0;
      rcw_reg <= 16'h0000;
      host_reg <= 1'b0;
      div_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        scg_pkg::ST_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg + 2'h1;
          if (wait_cnt_reg == scg_pkg::SYNC_WAIT) begin
            state_reg <= scg_pkg::ST_RUN;
            rcw_reg <= hard_sync_reg[1] ? scg_pkg::HARD_RCW : rcw_sync2_reg;
            host_reg <= host_sync_reg[1];
            div_reg <= div_sync_reg[1];
          end
        end
        scg_pkg::ST_RUN: begin
          wait_cnt_reg <= wait_cnt_reg;
        end
      endcase
    end
  end

  assign sys_mul = rcw_reg[scg_pkg::RCW_SYSMUL_POS +: 4];
  assign core_fld = rcw_reg[scg_pkg::RCW_CORE_POS +: 7];

  // ------------------------------------------------------------
  // Ratio decode
  // ------------------------------------------------------------
  // Reserved encodings are flagged; a reserved system multiplier makes the bus ratio read zero
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      csb_ratio_reg <= 4'h0;
      core_half_reg <= 4'h0;
      core_on_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (sys_mul >= scg_pkg::SYSMUL_MIN && sys_mul <= scg_pkg::SYSMUL_MAX) begin
        csb_ratio_reg <= div_reg ? 4'(sys_mul << 1) : sys_mul;
      end else begin
        csb_ratio_reg <= 4'h0;
      end
      core_half_reg <= core_halves(core_fld);
      core_on_reg <= core_fld[4:0] != 5'h00;
      err_reg <= sys_mul < scg_pkg::SYSMUL_MIN || sys_mul > scg_pkg::SYSMUL_MAX
        || core_fld[6:5] == scg_pkg::CORE_VCO_BAD || core_fld[4:1] > 4'h3
        || (core_fld[4:1] == 4'h3 && core_fld[0]) || (core_fld[4:1] == 4'h0 && core_fld[0]);
    end
  end

  // ------------------------------------------------------------
  // Primary reference and sync output
  // ------------------------------------------------------------
  // Agent mode takes the incoming bus clock as reference
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      prim_reg <= 1'b0;
    end else begin
      prim_reg <= host_reg ? sys_ref_sync_reg[1] : bus_ref_sync_reg[1];
    end
  end

  // Halving divider toggles on each sampled rising edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sys_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      sys_prev_reg <= sys_ref_sync_reg[1];
      if (sys_ref_sync_reg[1] && !sys_prev_reg) begin
        half_reg <= ~half_reg;
      end
      if (!host_reg) begin
        sync_reg <= 1'b0;
      end else begin
        sync_reg <= div_reg ? half_reg : sys_ref_sync_reg[1];
      end
    end
  end

  // ------------------------------------------------------------
  // Bus clock outputs
  // ------------------------------------------------------------
  // Enables change only while sync is low, so no runt pulse escapes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync_prev_reg <= 1'b0;
      gate_reg <= 3'h0;
      bus_out_reg <= 3'h0;
    end else begin
      sync_prev_reg <= sync_reg;
      if (!sync_reg) begin
        gate_reg <= outen_reg;
      end
      bus_out_reg <= gate_reg & {scg_pkg::NUM_BUS_OUT{sync_reg}};
    end
  end

  // ------------------------------------------------------------
  // Base ticks
  // ------------------------------------------------------------
  // The core clock stands for twice the bus clock; 1x modes use every other edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  assign csb_tick = phase_reg && state_reg == scg_pkg::ST_RUN;
  assign ddr_tick = rcw_reg[scg_pkg::RCW_MEMX2_POS] ? state_reg == scg_pkg::ST_RUN : csb_tick;
  assign lbc_tick = rcw_reg[scg_pkg::RCW_LBX2_POS] ? state_reg == scg_pkg::ST_RUN : csb_tick;

  // Registered tick copies for the outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      csb_en_reg <= 1'b0;
      ddr_en_reg <= 1'b0;
      lbc_en_reg <= 1'b0;
    end else begin
      csb_en_reg <= csb_tick;
      ddr_en_reg <= ddr_tick;
      lbc_en_reg <= lbc_tick;
    end
  end

  // ------------------------------------------------------------
  // Memory bus clock pair
  // ------------------------------------------------------------
  // One toggle per memory-controller tick halves it; the complement has its own flop
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      memclk_reg <= 1'b0;
      memclk_n_reg <= 1'b1;
    end else if (ddr_tick) begin
      memclk_reg <= ~memclk_reg;
      memclk_n_reg <= ~memclk_n_reg;
    end
  end

  // ------------------------------------------------------------
  // Local bus clock outputs
  // ------------------------------------------------------------
  // New divider taken only at the low-going boundary
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ldiv_act_reg <= 2'h0;
      lcnt_reg <= 2'h0;
      lbclk_reg <= 1'b0;
    end else if (lbc_tick) begin
      if (lcnt_reg == 2'h0) begin
        lbclk_reg <= ~lbclk_reg;
        if (lbclk_reg) begin
          ldiv_act_reg <= lbc_half(lbdiv_reg);
          lcnt_reg <= lbc_half(lbdiv_reg);
        end else begin
          lcnt_reg <= ldiv_act_reg;
        end
      end else begin
        lcnt_reg <= lcnt_reg - 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Unit clock rates
  // ------------------------------------------------------------
  scg_rate_div u_eth1 (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(csb_tick),
    .rate(units_reg[scg_pkg::UNITS_ETH1_POS +: 2]),
    .en_o(ETH1_CLK_EN)
  );

  scg_rate_div u_eth2 (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(csb_tick),
    .rate(units_reg[scg_pkg::UNITS_ETH2_POS +: 2]),
    .en_o(ETH2_CLK_EN)
  );

  scg_rate_div u_sec (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(csb_tick),
    .rate(units_reg[scg_pkg::UNITS_SEC_POS +: 2]),
    .en_o(SEC_CLK_EN)
  );

  scg_rate_div u_usb (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(csb_tick),
    .rate(units_reg[scg_pkg::UNITS_USB_POS +: 2]),
    .en_o(USB_CLK_EN)
  );

  // PCI and DMA complex is on or off only
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pci_en_reg <= 1'b0;
    end else begin
      pci_en_reg <= csb_tick && units_reg[scg_pkg::UNITS_PCI_POS];
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Unit rates default to full bus rate after reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      outen_reg <= scg_pkg::OUTEN_RST;
      lbdiv_reg <= scg_pkg::LBDIV_RST;
      units_reg <= scg_pkg::UNITS_RST;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        scg_pkg::OUTEN_OFS: outen_reg <= REG_WDATA[2:0];
        scg_pkg::LBDIV_OFS: lbdiv_reg <= REG_WDATA[1:0];
        scg_pkg::UNITS_OFS: units_reg <= REG_WDATA[8:0];
        default: outen_reg <= outen_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // Data stands for one cycle only; unmapped reads return zero
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        scg_pkg::OUTEN_OFS: rdata_reg <= {29'h0, outen_reg};
        scg_pkg::LBDIV_OFS: rdata_reg <= {30'h0, lbdiv_reg};
        scg_pkg::UNITS_OFS: rdata_reg <= {23'h0, units_reg};
        scg_pkg::CFGW_OFS: rdata_reg <= {16'h0, rcw_reg};
        scg_pkg::STAT_OFS: rdata_reg <= {19'h0, core_on_reg, core_half_reg, csb_ratio_reg,
          err_reg, div_reg, host_reg, state_reg == scg_pkg::ST_RUN};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign REG_RDATA = rdata_reg;
  assign PRIMARY_REF_CLK = prim_reg;
  assign SYNC_CLK_OUT = sync_reg;
  assign BUS_CLOCK_OUTPUTS = bus_out_reg;
  assign CSB_SYNC_RATIO = csb_ratio_reg;
  assign CORE_RATIO_HALVES = core_half_reg;
  assign CORE_PLL_ON = core_on_reg;
  assign CSB_CLK_EN = csb_en_reg;
  assign MEM_DATA_EN = ddr_en_reg;
  assign MEM_BUS_CLK_P = memclk_reg;
  assign MEM_BUS_CLK_N = memclk_n_reg; // Toggled with the true side, so the pair stays aligned
  assign LBC_CLK_EN = lbc_en_reg;
  assign LOCAL_BUS_CLOCK_OUT = {lbclk_reg, lbclk_reg};
  assign PCI_DMA_CLK_EN = pci_en_reg;
  assign CFG_VALID = state_reg[1]; // Run bit of the one-hot state flop
  assign CFG_ERROR = err_reg;
endmodule : scg_clock_gen

// >>> scg_pkg.sv
// Constants, register map and types for the system clock generation block
package scg_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OUTEN_OFS = 8'h00;
  localparam logic [7:0] LBDIV_OFS = 8'h04;
  localparam logic [7:0] UNITS_OFS = 8'h08;
  localparam logic [7:0] CFGW_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int NUM_BUS_OUT = 3;
  localparam logic [2:0] OUTEN_RST = 3'h0;
  localparam logic [1:0] LBDIV_RST = 2'h0;
  localparam int UNITS_ETH1_POS = 0;
  localparam int UNITS_ETH2_POS = 2;
  localparam int UNITS_SEC_POS = 4;
  localparam int UNITS_USB_POS = 6;
  localparam int UNITS_PCI_POS = 8;
  localparam logic [8:0] UNITS_RST = 9'h155;
  localparam logic [1:0] RATE_OFF = 2'h0;
  localparam logic [1:0] RATE_FULL = 2'h1;
  localparam logic [1:0] RATE_HALF = 2'h2;
  localparam logic [1:0] RATE_THIRD = 2'h3;
  localparam logic [1:0] LDIV_2 = 2'h0;
  localparam logic [1:0] LDIV_4 = 2'h1;
  // Reset configuration word low layout
  localparam int RCW_W = 16;
  localparam int RCW_LBX2_POS = 0;
  localparam int RCW_MEMX2_POS = 1;
  localparam int RCW_SYSMUL_POS = 2;
  localparam int RCW_CORE_POS = 6;
  localparam logic [3:0] SYSMUL_MIN = 4'h2;
  localparam logic [3:0] SYSMUL_MAX = 4'h6;
  localparam logic [1:0] CORE_VCO_BAD = 2'h3;
  // Hard-coded reset option (plain default: x4, core 2:1)
  localparam logic [RCW_W-1:0] HARD_RCW = 16'h0110;
  // Wait count reached after reset before straps are trusted
  localparam logic [1:0] SYNC_WAIT = 2'h3;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } scg_state_t;
endpackage : scg_pkg

// >>> scg_rate_div.sv
// Glitch-free rate divider producing a clock-enable pulse for one unit
`timescale 1ns/10ps
module scg_rate_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Base tick and requested rate
  input wire logic tick,
  input wire logic [1:0] rate,
  // Unit clock enable
  output logic en_o
);
  logic [1:0] cnt_reg;
  logic [1:0] act_reg;

  // Rate taken only at a period boundary, so no period is cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      act_reg <= scg_pkg::RATE_FULL;
    end else if (tick) begin
      if (cnt_reg == 2'h0 || act_reg == scg_pkg::RATE_OFF) begin
        act_reg <= rate;
        cnt_reg <= (rate == scg_pkg::RATE_OFF) ? 2'h0 : rate - 2'h1;
      end else begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

  // Pulse on the last tick of each unit period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_o <= 1'b0;
    end else begin
      en_o <= tick && cnt_reg == 2'h0 && act_reg != scg_pkg::RATE_OFF;
    end
  end
endmodule : scg_rate_div

// >>> scg_ref_osc.sv
// Model of the external oscillator and bus clock network
`timescale 1ns/10ps
module scg_ref_osc #(
  parameter int SYS_HALF = 4,
  parameter int BUS_HALF = 6
) (
  // Sampling clock
  input wire logic clk,
  // Agent mode grounds the system reference
  input wire logic agent,
  // Reference clocks
  output logic sys_ref,
  output logic bus_clk
);
  int sys_cnt = 0;
  int bus_cnt = 0;
  initial sys_ref = 1'b0;
  initial bus_clk = 1'b0;
  // Slow free-running sources keep every derived clock in range
  always @(posedge clk) begin
    sys_cnt <= (sys_cnt == SYS_HALF - 1) ? 0 : sys_cnt + 1;
    bus_cnt <= (bus_cnt == BUS_HALF - 1) ? 0 : bus_cnt + 1;
    if (agent) sys_ref <= 1'b0;
    else if (sys_cnt == SYS_HALF - 1) sys_ref <= !sys_ref;
    if (bus_cnt == BUS_HALF - 1) bus_clk <= !bus_clk;
  end
endmodule : scg_ref_osc

// >>> test_system_clock_generation.sv
// Self-checking bench for the system clock generation block
`timescale 1ns/10ps
module test_system_clock_generation;
  logic clk, rst, host, dv, hard, rd, wr, agent, sys_ref, bus_clk, prim, sync, csb, mem_en, mem_p, mem_n;
  logic lbc_en, eth1, eth2, sec, usb, pci, valid, cerr, pll_on;
  logic [15:0] rcw;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [2:0] bus_out;
  logic [3:0] csb_r, core_r;
  logic [1:0] local_bus_clock_out;
  logic [14:0] mon;
  int err_count, cmp_count;
  // Watched clocks, selected by index
  assign mon = {lbc_en, pci, usb, sec, eth2, eth1, mem_p, mem_en, local_bus_clock_out[0], csb, sync, prim, bus_out};
  scg_ref_osc osc (.clk(clk), .agent(agent), .sys_ref(sys_ref), .bus_clk(bus_clk));
  scg_clock_gen dut (.CORE_CLK(clk), .RST(rst), .SYS_REF_CLK_IN(sys_ref), .BUS_CLK_IN(bus_clk),
    .HOST_MODE_STRAP(host), .INPUT_DIVIDER_STRAP(dv), .RCW_HARD_SEL(hard), .RCW_EXT_LOW(rcw),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PRIMARY_REF_CLK(prim), .SYNC_CLK_OUT(sync), .BUS_CLOCK_OUTPUTS(bus_out), .CSB_SYNC_RATIO(csb_r),
    .CORE_RATIO_HALVES(core_r), .CORE_PLL_ON(pll_on), .CSB_CLK_EN(csb), .MEM_DATA_EN(mem_en),
    .MEM_BUS_CLK_P(mem_p), .MEM_BUS_CLK_N(mem_n), .LBC_CLK_EN(lbc_en), .LOCAL_BUS_CLOCK_OUT(local_bus_clock_out),
    .ETH1_CLK_EN(eth1), .ETH2_CLK_EN(eth2), .SEC_CLK_EN(sec), .USB_CLK_EN(usb), .PCI_DMA_CLK_EN(pci),
    .CFG_VALID(valid), .CFG_ERROR(cerr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Register port: strobes last one cycle, read data in the next cycle only
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Straps only change while reset is held, as a board would
  task automatic boot(input logic h, input logic v, input logic hs, input logic [15:0] w);
    @(posedge clk);
    rst <= 1'b1;
    host <= h;
    agent <= !h;
    dv <= v;
    hard <= hs;
    rcw <= w;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && valid !== 1'b1; i++) @(posedge clk);
    check("cfg_valid", {31'h0, valid}, 32'h1);
    repeat (4) @(posedge clk);
  endtask : boot
  // Counts rising edges over 96 cycles (high cycles for the data enable); one edge of slack
  task automatic count_check(input string name, input int idx, input logic [31:0] exp);
    logic [31:0] n;
    logic prev;
    n = 0;
    repeat (16) @(posedge clk);
    prev = mon[idx];
    repeat (96) begin
      @(posedge clk);
      if (mon[idx] === 1'b1 && (prev !== 1'b1 || idx == 7)) n++; // Data enable may stand high
      prev = mon[idx];
    end
    if (exp != 0 && (n + 1 == exp || n == exp + 1)) n = exp;
    check(name, n, exp);
  endtask : count_check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    finish_test();
  end
  // --------------------
  // Tests
  // --------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    {host, dv, hard, rd, wr, agent, addr, wdata, rcw} = '0;
    // Host, full sync, both doubling modes, x4 and core 2:1
    boot(1'b1, 1'b0, 1'b0, 16'h0113);
    rd_reg(scg_pkg::CFGW_OFS);
    check("cfg_word", d, 32'h113);
    rd_reg(scg_pkg::STAT_OFS);
    check("status", d, 32'h1443);
    count_check("primary", 3, 12);
    count_check("sync", 4, 12);
    count_check("csb", 5, 48);
    count_check("mem_data", 7, 96);
    count_check("mem_clk", 8, 48);
    rd_reg(scg_pkg::OUTEN_OFS);
    check("outen_rst", d, 32'(scg_pkg::OUTEN_RST));
    count_check("bus0_off", 0, 0);
    wr_reg(scg_pkg::OUTEN_OFS, 32'h5);
    count_check("bus0", 0, 12);
    count_check("bus1", 1, 0);
    count_check("bus2", 2, 12);
    for (int k = 0; k < 3; k++) begin
      wr_reg(scg_pkg::LBDIV_OFS, 32'(k));
      count_check("local_bus_clock_out", 6, 32'(48 >> k));
    end
    rd_reg(scg_pkg::UNITS_OFS);
    check("units_rst", d, 32'(scg_pkg::UNITS_RST));
    // Each unit through off, full, half and third with PCI gated off
    for (int u = 0; u < 4; u++) begin
      for (int r = 0; r < 4; r++) begin
        wr_reg(scg_pkg::UNITS_OFS, 32'(r) << (2 * u));
        count_check("unit", 9 + u, (r == 0) ? 32'h0 : 32'(48 / r));
      end
    end
    count_check("pci_off", 13, 0);
    wr_reg(scg_pkg::UNITS_OFS, 32'h100);
    count_check("pci_on", 13, 48);
    rd_reg(8'h14);
    check("unmapped", d, 32'h0);
    wr_reg(scg_pkg::CFGW_OFS, 32'h0);
    rd_reg(scg_pkg::CFGW_OFS);
    check("cfg_word_ro", d, 32'h113);
    $display("test host_full done");
    // Halved sync, x3, core bypass, no doubling
    boot(1'b1, 1'b1, 1'b0, 16'h000C);
    rd_reg(scg_pkg::STAT_OFS);
    check("status_div", d, 32'h267);
    count_check("sync_half", 4, 6);
    count_check("mem_data", 7, 48);
    count_check("mem_clk", 8, 24);
    count_check("local_bus_clock_out_x1", 6, 24);
    count_check("lbc_en", 14, 48);
    $display("test host_div done");
    // Every system multiplier and core ratio
    for (int k = 0; k < 5; k++) begin
      boot(1'b1, 1'b0, 1'b0, 16'((k + 2) << 2 | (1 + k / 2) << 7 | (k % 2) << 6));
      rd_reg(scg_pkg::STAT_OFS);
      check("ratios", d, 32'h1003 | 32'(k + 2) << 4 | 32'(k + 2) << 8);
    end
    boot(1'b1, 1'b0, 1'b0, 16'h009C);
    rd_reg(scg_pkg::STAT_OFS);
    check("sysmul_bad", {27'h0, d[7:3]}, 32'h1);
    $display("test ratios done");
    boot(1'b1, 1'b0, 1'b1, 16'hFFFF);
    rd_reg(scg_pkg::CFGW_OFS);
    check("hard_word", d, 32'(scg_pkg::HARD_RCW));
    $display("test hard_word done");
    // Agent mode follows the incoming bus clock, sync held low
    boot(1'b0, 1'b0, 1'b0, 16'h0113);
    rd_reg(scg_pkg::STAT_OFS);
    check("host_bit", {31'h0, d[1]}, 32'h0);
    count_check("primary_agent", 3, 8);
    count_check("sync_agent", 4, 0);
    $display("test agent done");
    finish_test();
  end
endmodule : test_system_clock_generation
